// File: logic/runaway_timer_pkg.sv
// Constants for the runaway watchdog timer block
package runaway_timer_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_COMMAND = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'hC;
    // Five-bit address for the enable register (byte address 0x10)
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;
    // ==========================================
    // Mode register fields
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_PERIOD_LSB = 4;
    localparam int MODE_IDLE_BIT = 2;
    localparam int MODE_ACTION_BIT = 1;
    localparam logic MODE_ENABLE_RST = 1'b1;
    localparam logic [2:0] MODE_PERIOD_RST = 3'h0;
    localparam logic MODE_IDLE_RST = 1'b0;
    localparam logic MODE_ACTION_RST = 1'b1;
    // ==========================================
    // Command codes
    localparam logic [7:0] CMD_DISABLE = 8'hB1;
    localparam logic [7:0] CMD_CLEAR = 8'h4E;
    // ==========================================
    // Counter and timing
    localparam int COUNT_WIDTH = 25;
    localparam logic [2:0] PERIOD_MAX_CODE = 3'h5;
    localparam logic [5:0] RESET_HOLD_STATES = 6'h20;
    // Status bits: 0 timeout, 1 prohibited period code seen
    localparam int IRQ_WIDTH = 2;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_BADCODE_BIT = 1;
endpackage

// File: logic/reset_stretch.sv
// Holds the internal reset request for a fixed number of states
`timescale 1ns/10ps
`default_nettype none
module reset_stretch
    import runaway_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Trigger and stretched output
    input wire logic i_fire,
    output logic o_hold
);
    logic [5:0] hold_count;

    // ==========================================
    // Hold counter
    // hold 32 states
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_count <= 6'h00;
        end else if (i_fire && hold_count == 6'h00) begin
            hold_count <= RESET_HOLD_STATES;
        end else if (hold_count != 6'h00) begin
            hold_count <= hold_count - 6'h01;
        end
    end

    assign o_hold = (hold_count != 6'h00);
endmodule
`default_nettype wire

// File: logic/runaway_timer.sv
// Runaway watchdog timer: counter, mode and command registers, interrupts
`timescale 1ns/10ps
`default_nettype none
module runaway_timer
    import runaway_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Processor state pins
    input wire logic i_idle_mode,
    input wire logic i_debug_mode,
    // Timeout outputs
    output logic o_timeout_interrupt,
    output logic o_internal_reset,
    output logic o_clock_reinit,
    output logic o_irq
);
    logic counter_enable;
    logic [2:0] period_select;
    logic idle_run;
    logic timeout_action_select;
    logic disable_armed;
    logic [COUNT_WIDTH-1:0] count;
    logic nmi_pending;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    // Pin order in the synchroniser vector
    localparam int PIN_IDLE = 0;
    localparam int PIN_DEBUG = 1;
    localparam int PIN_COUNT = 2;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_sync;
    logic idle_sync, debug_sync;
    logic [IRQ_WIDTH-1:0] status_event;
    logic wr_mode, wr_cmd, wr_clr, wr_en;
    logic cmd_clear, cmd_disable, run, expire, bad_code;
    logic [COUNT_WIDTH-1:0] limit;

    // Timeout count for a period code, all ones at the chosen width
    function automatic logic [COUNT_WIDTH-1:0] period_limit(input logic [2:0] code);
        logic [COUNT_WIDTH-1:0] value;
        value = '1;
        case (code)
            3'h0: value = {{(COUNT_WIDTH-15){1'b0}}, {15{1'b1}}};
            3'h1: value = {{(COUNT_WIDTH-17){1'b0}}, {17{1'b1}}};
            3'h2: value = {{(COUNT_WIDTH-19){1'b0}}, {19{1'b1}}};
            3'h3: value = {{(COUNT_WIDTH-21){1'b0}}, {21{1'b1}}};
            3'h4: value = {{(COUNT_WIDTH-23){1'b0}}, {23{1'b1}}};
            default: value = '1;
        endcase
        return value;
    endfunction

    // ==========================================
    // Pin synchronisers
    // Both pins are asynchronous, so each passes two flops before use
    assign pin_raw[PIN_IDLE] = i_idle_mode;
    assign pin_raw[PIN_DEBUG] = i_debug_mode;
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
        logic meta;
        logic held;
        // Only the second flop reads the first
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                meta <= 1'b0;
                held <= 1'b0;
            end else begin
                meta <= pin_raw[p];
                held <= meta;
            end
        end
        assign pin_sync[p] = held;
    end
    // Gating sees the pins two cycles late
    assign idle_sync = pin_sync[PIN_IDLE];
    assign debug_sync = pin_sync[PIN_DEBUG];

    // ==========================================
    // Address decode
    assign wr_mode = i_wr && (i_addr == {4'h0, ADDR_MODE});
    assign wr_cmd = i_wr && (i_addr == {4'h0, ADDR_COMMAND});
    assign wr_clr = i_wr && (i_addr == {4'h0, ADDR_IRQ_CLEAR});
    assign wr_en = i_wr && (i_addr == {3'h0, ADDR_IRQ_ENABLE});
    assign cmd_clear = wr_cmd && (i_wdata[7:0] == CMD_CLEAR);
    assign cmd_disable = wr_cmd && (i_wdata[7:0] == CMD_DISABLE);

    // ==========================================
    // Mode register
    // reset values
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            period_select <= MODE_PERIOD_RST;
            idle_run <= MODE_IDLE_RST;
            timeout_action_select <= MODE_ACTION_RST;
        end else if (o_internal_reset) begin
            period_select <= MODE_PERIOD_RST;
            idle_run <= MODE_IDLE_RST;
            timeout_action_select <= MODE_ACTION_RST;
        end else if (wr_mode) begin
            period_select <= i_wdata[MODE_PERIOD_LSB +: 3];
            idle_run <= i_wdata[MODE_IDLE_BIT];
            timeout_action_select <= i_wdata[MODE_ACTION_BIT];
        end
    end

    // ==========================================
    // Enable state: bit write arms, disable code completes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            disable_armed <= 1'b0;
            counter_enable <= MODE_ENABLE_RST;
        end else if (o_internal_reset) begin
            disable_armed <= 1'b0;
            counter_enable <= MODE_ENABLE_RST;
        end else if (wr_mode) begin
            disable_armed <= ~i_wdata[MODE_ENABLE_BIT];
            if (i_wdata[MODE_ENABLE_BIT]) begin
                counter_enable <= 1'b1;
            end
        end else if (cmd_disable && disable_armed) begin
            counter_enable <= 1'b0;
        end
    end

    // ==========================================
    // Binary counter
    assign limit = period_limit(period_select);
    assign run = counter_enable && !debug_sync && (idle_run || !idle_sync);
    assign expire = run && (count >= limit);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
        end else if (o_internal_reset) begin
            count <= '0;
        end else if (cmd_clear || (cmd_disable && disable_armed)) begin
            count <= '0;
        end else if (expire) begin
            count <= '0;
        end else if (run) begin
            count <= count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ==========================================
    // Timeout signalling
    // interrupt level until clear code or internal reset
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            nmi_pending <= 1'b0;
        end else if (expire && !timeout_action_select) begin
            nmi_pending <= 1'b1;
        end else if (cmd_clear || o_internal_reset) begin
            nmi_pending <= 1'b0;
        end
    end
    assign o_timeout_interrupt = nmi_pending;

    reset_stretch u_stretch (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_fire(expire && timeout_action_select),
        .o_hold(o_internal_reset)
    );
    // Clock selection returns to the oscillator while reset is held
    assign o_clock_reinit = o_internal_reset;

    // ==========================================
    // Interrupt status, set wins over clear
    // prohibited code flagged
    assign bad_code = (period_select > PERIOD_MAX_CODE);
    assign status_event[IRQ_TIMEOUT_BIT] = expire;
    assign status_event[IRQ_BADCODE_BIT] = bad_code;
    // One sticky bit per event; an event in the clear cycle is not lost
    for (genvar s = 0; s < IRQ_WIDTH; s++) begin : g_status
        logic sticky;
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                sticky <= 1'b0;
            end else if (status_event[s]) begin
                sticky <= 1'b1;
            end else if (wr_clr && i_wdata[s]) begin
                sticky <= 1'b0;
            end
        end
        assign irq_status[s] = sticky;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_enable <= '0;
        end else if (wr_en) begin
            irq_enable <= i_wdata[IRQ_WIDTH-1:0];
        end
    end
    assign o_irq = |(irq_status & irq_enable);

    // ==========================================
    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                {4'h0, ADDR_MODE}: o_rdata <= {24'h00_0000, counter_enable, period_select,
                    1'b0, idle_run, timeout_action_select, 1'b0};
                {4'h0, ADDR_IRQ_STATUS}: o_rdata <= {{(32-IRQ_WIDTH){1'b0}}, irq_status};
                {3'h0, ADDR_IRQ_ENABLE}: o_rdata <= {{(32-IRQ_WIDTH){1'b0}}, irq_enable};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// File: dv/runaway_timer_checker.sv
// Port assertions for the runaway watchdog timer
`timescale 1ns/10ps
`default_nettype none
module runaway_timer_checker
    import runaway_timer_pkg::*;
(
    // Clock, reset and register port
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Timeout outputs
    input wire logic o_timeout_interrupt,
    input wire logic o_internal_reset,
    input wire logic o_clock_reinit
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [6:0] hold_cnt;
    logic cmd;
    logic clr;
    // Command decode
    assign cmd = i_wr && i_addr == 8'(ADDR_COMMAND);
    assign clr = cmd && i_wdata[7:0] == CMD_CLEAR;
    // Length of the current internal reset pulse
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_cnt <= 7'h00;
        end else begin
            hold_cnt <= o_internal_reset ? hold_cnt + 7'h01 : 7'h00;
        end
    end
    // ==========================================
    // Assertions
    reinit_follows_a:
        assert property (o_clock_reinit == o_internal_reset) else $error("reinit differs");
    hold_exact_a:
        assert property ($fell(o_internal_reset) |-> hold_cnt == 7'h20) else $error("hold len");
    hold_max_a:
        assert property (hold_cnt <= 7'h20) else $error("hold too long");
    rdata_idle_a:
        assert property (!$past(i_rd) |-> o_rdata == '0) else $error("rdata not idle");
    mode_zero_a:
        assert property ($past(i_rd) && $past(i_addr) == 8'h00 |-> o_rdata[31:8] == '0
            && !o_rdata[3]) else $error("mode reserved bits");
    clear_quiet_a:
        assert property (clr |=> (!o_timeout_interrupt) [*8]) else $error("nmi after clear");
    clear_no_rst_a:
        assert property (clr && !o_internal_reset |=> (!o_internal_reset) [*8])
            else $error("reset after clear");
    nmi_stays_a:
        assert property (o_timeout_interrupt && !cmd && !o_internal_reset |=>
            o_timeout_interrupt) else $error("nmi dropped");
    other_code_a:
        assert property (cmd && i_wdata[7:0] != CMD_CLEAR && i_wdata[7:0] != CMD_DISABLE
            && o_timeout_interrupt |=> o_timeout_interrupt) else $error("code took effect");
endmodule
bind runaway_timer runaway_timer_checker runaway_timer_checker_i (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_timeout_interrupt(o_timeout_interrupt),
    .o_internal_reset(o_internal_reset), .o_clock_reinit(o_clock_reinit));
`default_nettype wire

// File: dv/runaway_timer_tb.sv
// Self-checking bench for the runaway watchdog timer
`timescale 1ns/10ps
`default_nettype none
module runaway_timer_tb;
    import runaway_timer_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0, i_rd = 1'b0, i_idle_mode = 1'b0, i_debug_mode = 1'b0;
    logic [31:0] o_rdata;
    logic o_timeout_interrupt, o_internal_reset, o_clock_reinit, o_irq, rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    int err_total = 0, n_checks = 0, cyc = 0, t0 = 0;
    runaway_timer runaway_timer_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_idle_mode(i_idle_mode), .i_debug_mode(i_debug_mode),
        .o_timeout_interrupt(o_timeout_interrupt), .o_internal_reset(o_internal_reset),
        .o_clock_reinit(o_clock_reinit), .o_irq(o_irq));
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    // Strobe low for one edge after each access, so no signal is set twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // Random command code that is neither clear nor disable
    function automatic logic [31:0] other();
        logic [7:0] c;
        c = 8'($urandom);
        if (c == CMD_CLEAR || c == CMD_DISABLE) begin
            c = 8'h00;
        end
        return {24'h00_0000, c};
    endfunction
    task automatic wait_hi(input logic which);
        int n = 0;
        while ((which ? o_internal_reset : o_timeout_interrupt) !== 1'b1 && n < 40000) begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================
    // Clock, cycle count and read monitor
    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        rd_seen <= i_rd;
    end
    // Read data stands only in the cycle after the strobe
    always @(negedge i_ref_clk) begin
        if (rd_seen) begin
            chk("rdata", exp_q.pop_front(), o_rdata);
        end
    end
    // Watchdog against a hang
    initial begin
        repeat (95000) @(posedge i_ref_clk);
        err_total++;
        results();
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h6db5));
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        rd(8'h00, 32'h0000_0082);
        wr(8'h10, 32'h0000_0001);
        rd(8'h10, 32'h0000_0001);
        wr(8'h00, 32'h0000_0080);
        wr(8'h04, 32'h0000_00B1);
        repeat (3000 + $urandom % 2000) @(posedge i_ref_clk);
        wr(8'h04, 32'h0000_004E);
        t0 = cyc;
        repeat (100) @(posedge i_ref_clk);
        i_idle_mode <= 1'b1;
        repeat (1000) @(posedge i_ref_clk);
        i_idle_mode <= 1'b0;
        i_debug_mode <= 1'b1;
        repeat (1000) @(posedge i_ref_clk);
        i_debug_mode <= 1'b0;
        wr(8'h04, other());
        wait_hi(1'b0);
        chk("nmi delay", 32'h1, 32'((cyc - t0) inside {[34760:34776]}));
        wr(8'h04, other());
        chk("nmi held", 32'h1, 32'(o_timeout_interrupt));
        rd(8'h08, 32'h0000_0001);
        chk("irq", 32'h1, 32'(o_irq));
        wr(8'h0C, 32'h0000_0001);
        chk("irq cleared", 32'h0, 32'(o_irq));
        wr(8'h04, 32'h0000_004E);
        chk("nmi cleared", 32'h0, 32'(o_timeout_interrupt));
        wr(8'h00, 32'h0000_00DE);
        rd(8'h00, 32'h0000_00D6);
        // Prohibited period code sets status bit 1, masked from the interrupt
        wr(8'h00, 32'h0000_00E6);
        rd(8'h00, 32'h0000_00E6);
        rd(8'h08, 32'h0000_0002);
        chk("irq masked", 32'h0, 32'(o_irq));
        wr(8'h00, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0002);
        wr(8'h04, 32'h0000_00B1);
        repeat (5000) @(posedge i_ref_clk);
        wr(8'h00, 32'h0000_0082);
        t0 = cyc;
        wait_hi(1'b1);
        chk("rst delay", 32'h1, 32'((cyc - t0) inside {[32760:32776]}));
        t0 = cyc;
        while (o_internal_reset === 1'b1 && cyc - t0 < 100) @(posedge i_ref_clk);
        chk("rst hold", 32'h1, 32'((cyc - t0) inside {[31:33]}));
        rd(8'h00, 32'h0000_0082);
        rd(8'h20, 32'h0000_0000);
        rd(8'h08, 32'h0000_0001);
        repeat (2) @(posedge i_ref_clk);
        results();
    end
endmodule
`default_nettype wire
